// ### inc/sgt_pkg.sv
// constants, types and helpers of the system guard timer block
package sgt_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [12:0] OFS_FLASH_CFG2 = 13'h1050;
    localparam logic [12:0] OFS_SERIAL_MH = 13'h1058;
    localparam logic [12:0] OFS_SERIAL_ML = 13'h105c;
    localparam logic [12:0] OFS_SERIAL_L = 13'h1060;
    localparam logic [12:0] OFS_GUARD_CTRL = 13'h1100;
    localparam logic [12:0] OFS_GUARD_SVC = 13'h1104;
    localparam logic [12:0] OFS_IRQ_STATUS = 13'h1108;
    localparam logic [12:0] OFS_IRQ_MASK = 13'h110c;
    localparam logic [12:0] OFS_GUARD_COUNT = 13'h1110;

    // ==========================================================
    // field positions and reset values
    localparam int CTRL_TSEL_LSB = 2;
    localparam int CTRL_CLKSEL_BIT = 1;
    localparam int CTRL_WINDOW_BIT = 0;
    localparam int IRQ_TIMEOUT_BIT = 0;
    localparam int IRQ_EARLY_BIT = 1;
    localparam int IRQ_BADKEY_BIT = 2;
    localparam logic [3:0] GUARD_CTRL_RESET = 4'h0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [6:0] FLASH_END_DEFAULT = 7'h10;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // ==========================================================
    // timeout periods in ticks of the selected source
    localparam logic [1:0] TSEL_OFF = 2'h0;
    localparam logic [1:0] TSEL_SHORT = 2'h1;
    localparam logic [1:0] TSEL_MID = 2'h2;
    localparam logic [18:0] PERIOD_LPO_SHORT = 19'h00020;
    localparam logic [18:0] PERIOD_LPO_MID = 19'h00100;
    localparam logic [18:0] PERIOD_LPO_LONG = 19'h00400;
    localparam logic [18:0] PERIOD_BUS_SHORT = 19'h02000;
    localparam logic [18:0] PERIOD_BUS_MID = 19'h10000;
    localparam logic [18:0] PERIOD_BUS_LONG = 19'h40000;

    // ==========================================================
    // types
    typedef struct packed {
        logic [1:0] tsel;
        logic clk_sel;
        logic window;
    } sgt_ctrl_t;

    typedef struct packed {
        logic badkey;
        logic early;
        logic timeout;
    } sgt_irq_t;

    // window opens three quarters into the period
    function automatic logic [18:0] sgt_window_start(input logic [18:0] p);
        return p - (p >> 2);
    endfunction

endpackage

// ### verilog/sgt_counter.sv
// timeout counter of the guard timer
module sgt_counter
    import sgt_pkg::*;
#(
    parameter int WIDTH = 19
)(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // control
    input wire logic i_tick,
    input wire logic i_clear,
    input wire logic [WIDTH-1:0] i_period,
    // state
    output logic [WIDTH-1:0] o_count,
    output logic o_expired
);

    // ==========================================================
    // counting
    logic [WIDTH-1:0] last;
    assign last = i_period - WIDTH'(1);

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_count <= '0;
        end else if (i_clear) begin
            o_count <= '0;
        end else if (i_tick) begin
            // wrap so a missed reset request still retriggers
            o_count <= (o_count == last) ? '0 : o_count + WIDTH'(1);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_expired <= 1'b0;
        end else begin
            o_expired <= i_tick & ~i_clear & (o_count == last);
        end
    end

endmodule

// ### verilog/sgt_top.sv
// guard timer, flash end and unique serial registers on avalon-mm
//
// What this block does
// RQ1 - control register bits accept only the first write after reset
// RQ2 - timeout select: off, 2^5/2^13, 2^8/2^16, 2^10/2^18 cycles
// RQ3 - clock select 0 uses the 1 kHz oscillator, 1 the bus clock
// RQ4 - bit 0 picks windowed mode, honoured only on the bus clock
// RQ5 - service window opens at three quarters of the timeout period
// RQ6 - writing 0x55 then 0xaa to the service byte restarts the counter
// RQ7 - flash end field at bits 30-24 gives first unimplemented address
// RQ8 - bit 23 of flash configuration always reads one
// RQ9 - reserved fields of flash configuration and control read zero
// RQ10 - three read-only registers return the 80-bit unique serial
// RQ11 - flash end field maps to address bits 19-13
// RQ12 - unserviced expiry of the enabled timer requests a system reset
//
// The Avalon-MM register port was chosen for this implementation.
module sgt_top
    import sgt_pkg::*;
#(
    parameter logic [6:0] FLASH_END_BLOCK = FLASH_END_DEFAULT,
    // value is arbitrary
    parameter logic [79:0] UNIQUE_SERIAL = 80'h0123_4567_89ab_cdef_0f1e,
    parameter logic [18:0] BUS_SHORT = PERIOD_BUS_SHORT,
    parameter logic [18:0] BUS_MID = PERIOD_BUS_MID,
    parameter logic [18:0] BUS_LONG = PERIOD_BUS_LONG
)(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // avalon-mm slave
    input wire logic [12:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // low power oscillator pin
    input wire logic i_lpo_clk,
    // system outputs
    output logic o_reset_req,
    output logic o_irq
);

    // ==========================================================
    // bus handshake
    logic wr_fire;
    logic wr_ok;
    logic [31:0] next_readdata;

    assign wr_fire = i_write & ~i_read & ~o_waitrequest;
    assign wr_ok = wr_fire & i_byteenable[0];

    // one wait cycle per access, answer taken at the second edge
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_waitrequest <= 1'b1;
        end else if ((i_read | i_write) && o_waitrequest) begin
            o_waitrequest <= 1'b0;
        end else begin
            o_waitrequest <= 1'b1;
        end
    end

    // operands are arguments so continuous assigns track every change
    function automatic logic hit(input logic en, input logic [12:0] a,
                                 input logic [12:0] ofs);
        return en && a == ofs;
    endfunction

    // ==========================================================
    // control register
    sgt_ctrl_t ctrl;
    logic ctrl_locked;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl <= GUARD_CTRL_RESET;
            ctrl_locked <= 1'b0;
        end else if (hit(wr_ok, i_address, OFS_GUARD_CTRL) &&
                     !ctrl_locked) begin
            ctrl <= i_writedata[3:0]; // RQ1
            ctrl_locked <= 1'b1; // RQ1
        end
    end

    logic enabled;
    logic win_on;
    logic [18:0] period;

    assign enabled = ctrl.tsel != TSEL_OFF;
    assign win_on = ctrl.window & ctrl.clk_sel; // RQ4

    always_comb begin
        unique case (ctrl.tsel) // RQ2
            TSEL_OFF: period = BUS_LONG;
            TSEL_SHORT: period = ctrl.clk_sel ? BUS_SHORT : PERIOD_LPO_SHORT;
            TSEL_MID: period = ctrl.clk_sel ? BUS_MID : PERIOD_LPO_MID;
            default: period = ctrl.clk_sel ? BUS_LONG : PERIOD_LPO_LONG;
        endcase
    end

    // ==========================================================
    // oscillator synchroniser and tick
    logic lpo_meta;
    logic lpo_sync;
    logic lpo_prev;
    logic lpo_tick;
    logic tick;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            lpo_meta <= 1'b0;
            lpo_sync <= 1'b0;
            lpo_prev <= 1'b0;
        end else begin
            lpo_meta <= i_lpo_clk;
            lpo_sync <= lpo_meta;
            lpo_prev <= lpo_sync;
        end
    end

    assign lpo_tick = lpo_sync & ~lpo_prev;
    assign tick = enabled & (ctrl.clk_sel | lpo_tick); // RQ3

    // ==========================================================
    // service key sequence
    typedef enum logic {SRV_IDLE, SRV_ARMED} sgt_srv_t;
    sgt_srv_t srv_state;
    logic key_write;
    logic is_first;
    logic is_second;
    logic service_done;
    logic bad_key;

    assign key_write = hit(wr_ok, i_address, OFS_GUARD_SVC);
    assign is_first = i_writedata[7:0] == KEY_FIRST;
    assign is_second = i_writedata[7:0] == KEY_SECOND;
    assign service_done = key_write & is_second & (srv_state == SRV_ARMED);
    assign bad_key = key_write & ~is_first & ~service_done;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            srv_state <= SRV_IDLE;
        end else if (key_write) begin
            // any other value breaks the pair
            srv_state <= is_first ? SRV_ARMED : SRV_IDLE; // RQ6
        end
    end

    // ==========================================================
    // counter, window and reset request
    logic [18:0] count;
    logic expired;
    logic win_open;
    logic early;
    logic restart;

    assign win_open = count >= sgt_window_start(period); // RQ5
    // servicing before the window opens counts as a fault
    assign early = service_done & enabled & win_on & ~win_open; // RQ5
    assign restart = service_done & ~early; // RQ6

    sgt_counter #(
        .WIDTH(19)
    ) u_counter (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_tick(tick),
        .i_clear(restart | ~enabled),
        .i_period(period),
        .o_count(count),
        .o_expired(expired)
    );

    // held until the system reset that it asks for arrives
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reset_req <= 1'b0;
        end else if (expired | early) begin
            o_reset_req <= 1'b1; // RQ12
        end
    end

    // ==========================================================
    // interrupt status and mask
    sgt_irq_t irq_status;
    sgt_irq_t irq_mask;
    sgt_irq_t irq_set;
    sgt_irq_t irq_clr;
    sgt_irq_t next_status;

    assign irq_set = '{badkey: bad_key, early: early, timeout: expired};
    assign irq_clr = hit(wr_ok, i_address, OFS_IRQ_STATUS) ?
                     i_writedata[2:0] : 3'h0;
    // set wins over a clear in the same cycle
    assign next_status = (irq_status & ~irq_clr) | irq_set;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_status;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_mask <= IRQ_MASK_RESET;
        end else if (hit(wr_ok, i_address, OFS_IRQ_MASK)) begin
            irq_mask <= i_writedata[2:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(next_status & irq_mask);
        end
    end

    // ==========================================================
    // read data
    always_comb begin
        unique case (i_address)
            OFS_FLASH_CFG2: begin
                // field is address bits 19-13 of the first hole
                next_readdata = {1'b0, FLASH_END_BLOCK, 1'b1,
                                 7'h00, 16'h0000}; // RQ7 RQ8 RQ9 RQ11
            end
            OFS_SERIAL_MH: next_readdata = {16'h0000,
                                            UNIQUE_SERIAL[79:64]}; // RQ10
            OFS_SERIAL_ML: next_readdata = UNIQUE_SERIAL[63:32]; // RQ10
            OFS_SERIAL_L: next_readdata = UNIQUE_SERIAL[31:0]; // RQ10
            OFS_GUARD_CTRL: next_readdata = {28'h0000000, ctrl}; // RQ9
            OFS_IRQ_STATUS: next_readdata = {29'h00000000, irq_status};
            OFS_IRQ_MASK: next_readdata = {29'h00000000, irq_mask};
            OFS_GUARD_COUNT: next_readdata = {13'h0000, count};
            default: next_readdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_readdata <= 32'h00000000;
        end else if (i_read && o_waitrequest) begin
            o_readdata <= next_readdata;
        end
    end

    // ==========================================================
    // assertions
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_key_first;
        key_write && is_first;
    endsequence

    sequence s_key_second;
        key_write && is_second;
    endsequence

    a_ctrl_write_once: assert property ( // RQ1
        ctrl_locked |=> $stable(ctrl) && ctrl_locked)
        else $error("control changed after first write");

    a_timer_off_idle: assert property ( // RQ2
        ctrl.tsel == TSEL_OFF |=> count == 19'h00000 && !expired)
        else $error("disabled timer is counting");

    a_period_length: assert property ( // RQ2
        expired |-> $past(count) == $past(period) - 19'h00001)
        else $error("expiry not at the selected period");

    a_bus_clock_tick: assert property ( // RQ3
        enabled && ctrl.clk_sel && !restart &&
        count < period - 19'h00001
        |=> count == $past(count) + 19'h00001)
        else $error("bus clock source did not advance count");

    a_lpo_clock_hold: assert property ( // RQ3
        enabled && !ctrl.clk_sel && !lpo_tick && !restart
        |=> $stable(count))
        else $error("count moved without an oscillator edge");

    a_window_lpo_off: assert property ( // RQ4
        service_done && !ctrl.clk_sel |-> !early)
        else $error("window applied on oscillator source");

    a_window_early: assert property ( // RQ5
        service_done && enabled && win_on &&
        count < sgt_window_start(period)
        |=> o_reset_req && irq_status.early)
        else $error("service before window went unpunished");

    a_key_restart: assert property ( // RQ6
        s_key_first ##[2:3] s_key_second ##0 (enabled && !early)
        |-> service_done ##1 count == 19'h00000)
        else $error("ordered key pair did not restart counter");

    a_key_needs_first: assert property ( // RQ6
        key_write && !is_first |=> srv_state == SRV_IDLE)
        else $error("non-first key left the pair armed");

    a_flash_cfg_read: assert property ( // RQ7
        i_read && o_waitrequest && i_address == OFS_FLASH_CFG2
        |=> o_readdata[31:23] == {1'b0, FLASH_END_BLOCK, 1'b1} &&
        o_readdata[22:0] == 23'h000000) // RQ8 RQ9
        else $error("flash configuration read wrong");

    a_serial_upper: assert property ( // RQ10
        i_read && o_waitrequest && i_address == OFS_SERIAL_MH
        |=> o_readdata == {16'h0000, UNIQUE_SERIAL[79:64]})
        else $error("upper serial register read wrong");

    a_expiry_reset: assert property ( // RQ12
        expired |=> o_reset_req [*3])
        else $error("expiry did not hold a reset request");

endmodule

// ### tb/tb.sv
// self-checking bench of the guard timer, flash end and serial registers
module tb
    import sgt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // settings
    // a 128 KB flash ends at 0x0002_0000, field holds address bits 19-13
    localparam logic [6:0] FEB = 7'(32'h0002_0000 >> 13);
    // value is arbitrary
    localparam logic [79:0] SER = 80'h5a3c_1122_3344_5566_7788;
    // shortened bus-clock periods keep the run brief
    localparam logic [18:0] PS = 19'h00010;
    localparam logic [31:0] FCFG = {1'b0, FEB, 1'b1, 23'h0};

    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic [12:0] i_address;
    logic i_read;
    logic i_write;
    logic [31:0] i_writedata;
    logic [3:0] i_byteenable;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic i_lpo_clk = 1'b0;
    logic o_reset_req;
    logic o_irq;
    logic [2:0] lpo_div = 3'h0;
    logic [31:0] rd;
    int err_total;
    int n_compared;
    int n;
    int p;

    always #5 i_mclk = ~i_mclk;

    // oscillator stand-in: one rising edge every 8 bus cycles
    always @(posedge i_mclk) begin
        lpo_div <= lpo_div + 3'h1;
        i_lpo_clk <= lpo_div[2];
    end

    sgt_top #(
        .FLASH_END_BLOCK(FEB),
        .UNIQUE_SERIAL(SER),
        .BUS_SHORT(PS),
        .BUS_MID(19'h00020),
        .BUS_LONG(19'h00040)
    ) dut (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_address(i_address),
        .i_read(i_read),
        .i_write(i_write),
        .i_writedata(i_writedata),
        .i_byteenable(i_byteenable),
        .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest),
        .i_lpo_clk(i_lpo_clk),
        .o_reset_req(o_reset_req),
        .o_irq(o_irq)
    );

    // ==========================================================
    // reporting
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: flag %b expected %b",
                $time, got, exp);
        end
    endtask

    // ==========================================================
    // avalon-mm master
    task automatic bus(input logic is_wr, input logic [12:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int k;
        @(posedge i_mclk);
        i_address <= a;
        i_read <= !is_wr;
        i_write <= is_wr;
        i_writedata <= d;
        i_byteenable <= be;
        k = 0;
        do begin
            @(posedge i_mclk);
            k++;
        end while (o_waitrequest !== 1'b0 && k < 20);
        if (o_waitrequest !== 1'b0) begin
            err_total++;
            $display("CHECK FAILED at %0t: bus access hangs", $time);
            end_sim();
        end else begin
            rd = o_readdata;
            i_read <= 1'b0;
            i_write <= 1'b0;
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rdc(input logic [12:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        chk32(rd, exp);
    endtask

    task automatic svc();
        wr(OFS_GUARD_SVC, 32'h55);
        wr(OFS_GUARD_SVC, 32'haa);
    endtask

    // counts cycles until the reset request shows; a missed one ends the run when must is set
    task automatic wait_req(input logic must, input int lim);
        n = 0;
        while (o_reset_req !== 1'b1 && n < lim) begin
            @(posedge i_mclk);
            n++;
        end
        if (must && o_reset_req !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED at %0t: no reset request", $time);
            end_sim();
        end
    endtask

    task automatic rst();
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_mclk);
        i_rstn <= 1'b1;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        i_address = 13'h0;
        i_read = 1'b0;
        i_write = 1'b0;
        i_writedata = 32'h0;
        i_byteenable = 4'h0;
        err_total = 0;
        n_compared = 0;
        rst();
        rdc(OFS_FLASH_CFG2, FCFG);
        wr(OFS_FLASH_CFG2, 32'h0);
        rdc(OFS_FLASH_CFG2, FCFG);
        rdc(OFS_SERIAL_MH, {16'h0, SER[79:64]});
        rdc(OFS_SERIAL_ML, SER[63:32]);
        rdc(OFS_SERIAL_L, SER[31:0]);
        rdc(13'h0ffc, 32'h0);
        rdc(OFS_IRQ_MASK, 32'h0);
        rdc(OFS_GUARD_CTRL, 32'h0);
        wait_req(1'b0, 100);
        chk1(o_reset_req, 1'b0);
        // bad key: raised while masked, then unmasked and cleared
        wr(OFS_GUARD_SVC, 32'h33);
        repeat (2) @(posedge i_mclk);
        chk1(o_irq, 1'b0);
        rdc(OFS_IRQ_STATUS, 32'h4);
        wr(OFS_IRQ_MASK, 32'h4);
        repeat (2) @(posedge i_mclk);
        chk1(o_irq, 1'b1);
        wr(OFS_IRQ_STATUS, 32'h4);
        repeat (2) @(posedge i_mclk);
        chk1(o_irq, 1'b0);
        rdc(OFS_IRQ_STATUS, 32'h0);
        // a write without lane 0 must not change the control register
        bus(1'b1, OFS_GUARD_CTRL, 32'hf, 4'he);
        rdc(OFS_GUARD_CTRL, 32'h0);
        // the three enabled timeout selects on the bus clock, normal mode
        for (int t = 1; t < 4; t++) begin
            rst();
            p = int'(PS) << (t - 1);
            wr(OFS_GUARD_CTRL, 32'hffff_fff2 | (t << 2));
            svc();
            wr(OFS_GUARD_CTRL, 32'h0);
            rdc(OFS_GUARD_CTRL, 32'h2 | (t << 2));
            svc();
            svc();
            chk1(o_reset_req, 1'b0);
            wait_req(1'b1, 200);
            chk1(n >= p && n <= p + 4, 1'b1);
            rdc(OFS_IRQ_STATUS, 32'h1);
        end
        // windowed: service inside the window restarts, early one resets
        rst();
        wr(OFS_GUARD_CTRL, 32'h7);
        wr(OFS_GUARD_SVC, 32'h55);
        repeat (7) @(posedge i_mclk);
        wr(OFS_GUARD_SVC, 32'haa);
        repeat (3) @(posedge i_mclk);
        chk1(o_reset_req, 1'b0);
        svc();
        wait_req(1'b0, 8);
        chk1(o_reset_req, 1'b1);
        rdc(OFS_IRQ_STATUS, 32'h2);
        // oscillator source ignores the window and counts its ticks
        rst();
        wr(OFS_GUARD_CTRL, 32'h5);
        svc();
        wait_req(1'b0, 8);
        chk1(o_reset_req, 1'b0);
        wait_req(1'b1, 400);
        chk1(n >= 220 && n <= 290, 1'b1);
        // reversed pair: a lone 0xaa is a bad key and must not restart
        rst();
        wr(OFS_GUARD_CTRL, 32'h6);
        wr(OFS_GUARD_SVC, 32'haa);
        wr(OFS_GUARD_SVC, 32'h55);
        wait_req(1'b1, 40);
        chk1(n < int'(PS) - 2, 1'b1);
        rdc(OFS_IRQ_STATUS, 32'h5);
        end_sim();
    end
endmodule
